// File: eeprom_cmd.sv
// Serial EEPROM command engine: three-wire link, enable latch, self-timed array cycles
// Contract
// - Erase sets every bit of the addressed word to one.
// - Erase cycle starts at select fall, or at final address bit edge in clocked variant.
// - After select returns high during a cycle, output shows 0 busy, 1 ready.
// - Start bit then select low clears the status display; output goes high impedance.
// - Erase-all sets whole array to one, started like a single erase.
// - A started cycle finishes without further serial clock edges.
// - Powers up program-disabled; enable needed before erase or write; stays until disabled.
// - Reads work in either enable state; master should disable after programming.
// - Read gives a dummy zero, then 8 or 16 data bits MSB first.
// - Read bits change after a rising serial clock edge, stable until the next.
// - Select held high continues reading consecutive addresses.
// - Write takes 8 or 16 data bits; cycle starts at select fall or last data edge.
// - Write-all erases then writes the word into every location.
// - Write-all only acts while programming is enabled.
// - Select low enters standby only after a running cycle ends.
// - Select low holds command logic reset, dropping partial instructions.
// - Bits sampled and read data launched on the serial clock rising edge.
// - Serial clock may pause at either level anywhere.
// - Before a start bit, clocks with input low are ignored.
// - Exact edge count per instruction; later clocks ignored until next start.
// - Select low through a whole cycle keeps output off; later status shows ready.
// - Start bit is first rising edge with select and input both high.
// - Two-bit opcode, special subcodes in top address bits, 9 or 8 address bits.
// - Organization input high picks 16-bit words, low picks 8-bit.
// - Output off except read data or status; off at select fall.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_cmd_cfg.svh"

module eeprom_cmd
  import eeprom_cmd_pkg::*;
#(
  parameter bit          CLK_TRIGGERED = 1'b0,
  parameter int unsigned PROG_CYCLES   = `T_PROG_MS * `CORE_CLK_KHZ,
  parameter int unsigned ERASE_WHOLE_ARRAY_CYCLES   = `T_ERASE_WHOLE_ARRAY_MS * `CORE_CLK_KHZ,
  parameter int unsigned WRITE_WHOLE_ARRAY_CYCLES   = `T_WRITE_WHOLE_ARRAY_MS * `CORE_CLK_KHZ
) (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic select_i,
  input  wire logic sclk_i,
  input  wire logic serial_in_i,
  input  wire logic word_width_select_i,
  output logic      serial_out_o,
  output logic      serial_out_oe_o
);

  // Pin sampling: all four pins come from the master's domain
  pins_t pins_raw;
  pins_t pins_meta;
  pins_t pins;
  logic  sclk_prev;
  logic  sel_prev;

  assign pins_raw = '{select: select_i, sclk: sclk_i, din: serial_in_i,
                      wide: word_width_select_i};

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_meta <= '0;
      pins      <= '0;
      sclk_prev <= 1'b0;
      sel_prev  <= 1'b0;
    end else begin
      pins_meta <= pins_raw;
      pins      <= pins_meta;
      sclk_prev <= pins.sclk;
      sel_prev  <= pins.select;
    end
  end

  logic clk_rise;
  logic sel_fall;
  logic sel_rise;
  // Edges are found on the sampled clock, so a paused clock simply yields no edge
  assign clk_rise = pins.sclk & ~sclk_prev;
  assign sel_fall = ~pins.select & sel_prev;
  assign sel_rise = pins.select & ~sel_prev;

  logic [7:0] mem [0:`LAST_BYTE];

  function automatic logic [4:0] addr_bits(input logic w);
    return w ? `ADDR_BITS_X16 : `ADDR_BITS_X8;
  endfunction : addr_bits

  function automatic logic [4:0] data_bits(input logic w);
    return w ? `DATA_BITS_X16 : `DATA_BITS_X8;
  endfunction : data_bits

  // Byte array holds 16-bit words high byte first at the even address
  function automatic logic [15:0] read_word(input logic [`BYTE_ADDR_W-1:0] a, input logic w);
    if (w) begin
      return {mem[{a[7:0], 1'b0}], mem[{a[7:0], 1'b1}]};
    end
    return {mem[a], 8'h00};
  endfunction : read_word

  function automatic logic [`BYTE_ADDR_W-1:0] next_address(input logic [`BYTE_ADDR_W-1:0] a,
                                                         input logic w);
    logic [`BYTE_ADDR_W-1:0] n;
    n = a + `BYTE_ADDR_W'(1);
    return w ? {1'b0, n[7:0]} : n;
  endfunction : next_address

  // Command group
  link_state_t             state,        next_state;
  logic [4:0]              bit_cnt,      next_cnt;
  logic [`SHIFT_W-1:0]     sr,           next_sr;
  logic [`BYTE_ADDR_W-1:0] addr,         next_addr;
  logic                    prog_en,      next_prog_en;
  logic                    armed,        next_armed;
  prog_req_t               req,          next_req;
  logic                    start_seen,   next_start_seen;
  logic                    status_armed, next_status_armed;
  logic                    status_show,  next_status_show;
  logic                    rd_bit,       next_rd_bit;
  logic [15:0]             dout_sr,      next_dout;
  logic [4:0]              rd_left,      next_left;
  logic                    next_out,     next_oe;
  logic                    go;
  prog_req_t               go_req;
  logic                    prog_busy;

  logic [`SHIFT_W-1:0]     sr_in;
  logic [4:0]              cnt_inc;
  logic [4:0]              addr_end;
  logic [1:0]              opc_dec;
  logic [`BYTE_ADDR_W-1:0] addr_dec;
  logic [1:0]              sub_dec;
  logic                    fin;
  prog_kind_t              fin_kind;
  logic [15:0]             fin_data;

  always_comb begin
    next_state        = state;
    next_cnt          = bit_cnt;
    next_sr           = sr;
    next_addr         = addr;
    next_prog_en      = prog_en;
    next_armed        = armed;
    next_req          = req;
    next_start_seen   = start_seen;
    next_status_armed = status_armed;
    next_status_show  = status_show;
    next_rd_bit       = rd_bit;
    next_dout         = dout_sr;
    next_left         = rd_left;
    go                = 1'b0;
    go_req            = req;
    fin               = 1'b0;
    fin_kind          = PK_NONE;
    fin_data          = 16'h0000;
    sr_in             = {sr[`SHIFT_W-2:0], pins.din};
    cnt_inc           = bit_cnt + 5'h01;
    addr_end          = `OPC_BITS + addr_bits(pins.wide);
    opc_dec           = pins.wide ? sr_in[9:8] : sr_in[10:9];
    addr_dec          = pins.wide ? {1'b0, sr_in[7:0]} : sr_in[8:0];
    sub_dec           = pins.wide ? sr_in[7:6] : sr_in[8:7];
    if (sel_fall && armed && !prog_busy) begin
      go = 1'b1;
    end
    if (!pins.select) begin
      // Deselected: partial instruction dropped, enable latch and cycle untouched
      next_state       = ST_IDLE;
      next_cnt         = 5'h00;
      next_armed       = 1'b0;
      next_start_seen  = 1'b0;
      next_status_show = 1'b0;
      if (sel_fall && start_seen) begin
        next_status_armed = 1'b0;
      end
    end else begin
      if (sel_rise && status_armed) begin
        next_status_show = 1'b1;
      end
      if (clk_rise) begin
        case (state)
          ST_IDLE: begin
            if (pins.din) begin
              next_state      = ST_SHIFT;
              next_cnt        = 5'h00;
              next_start_seen = 1'b1;
            end
          end
          ST_SHIFT: begin
            next_sr  = sr_in;
            next_cnt = cnt_inc;
            if (cnt_inc == addr_end) begin
              next_addr = addr_dec;
              case (opc_dec)
                `OPC_READ: begin
                  next_state  = ST_READ;
                  next_rd_bit = `DUMMY_BIT;
                  next_dout   = read_word(addr_dec, pins.wide);
                  next_left   = data_bits(pins.wide);
                end
                `OPC_ERASE: begin
                  fin      = 1'b1;
                  fin_kind = PK_ERASE;
                end
                `OPC_WRITE: begin
                  next_req.kind = PK_WRITE;
                end
                `OPC_SPECIAL: begin
                  if (sub_dec == `SUB_ERASE_WHOLE_ARRAY) begin
                    fin      = 1'b1;
                    fin_kind = PK_ERASE_WHOLE_ARRAY;
                  end else if (sub_dec == `SUB_ENABLE) begin
                    next_prog_en = 1'b1;
                    next_state   = ST_HOLD;
                  end else if (sub_dec == `SUB_DISABLE) begin
                    next_prog_en = 1'b0;
                    next_state   = ST_HOLD;
                  end else begin
                    next_req.kind = PK_WRITE_WHOLE_ARRAY;
                  end
                end
                default: ;
              endcase
            end else if (cnt_inc == addr_end + data_bits(pins.wide)) begin
              fin      = 1'b1;
              // Opcode and address have left the decode window, so use the latched ones
              fin_kind = req.kind;
              fin_data = pins.wide ? sr_in[15:0] : {8'h00, sr_in[7:0]};
            end
          end
          ST_READ: begin
            next_rd_bit = dout_sr[15];
            next_dout   = {dout_sr[14:0], 1'b0};
            next_left   = rd_left - 5'h01;
            if (rd_left == 5'h01) begin
              next_addr = next_address(addr, pins.wide);
              next_dout = read_word(next_address(addr, pins.wide), pins.wide);
              next_left = data_bits(pins.wide);
            end
          end
          ST_HOLD: ;
          default: next_state = ST_IDLE;
        endcase
      end
    end
    if (fin) begin
      next_state = ST_HOLD;
      // Disabled latch: the instruction is swallowed and the array stays as is
      if (prog_en) begin
        next_req = '{kind: fin_kind, wide: pins.wide, addr: next_addr, data: fin_data};
        if (CLK_TRIGGERED) begin
          go     = !prog_busy;
          go_req = next_req;
          // A cycle started here must keep its status past the coming select fall
          next_start_seen = prog_busy;
        end else begin
          next_armed = 1'b1;
        end
      end
    end
    if (go) begin
      next_status_armed = 1'b1;
    end
    next_oe  = 1'b0;
    next_out = 1'b0;
    if (pins.select) begin
      if (next_state == ST_READ) begin
        next_oe  = 1'b1;
        next_out = next_rd_bit;
      end else if (next_status_show) begin
        next_oe  = 1'b1;
        next_out = !(prog_busy || go);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state           <= ST_IDLE;
      bit_cnt         <= 5'h00;
      sr              <= '0;
      addr            <= '0;
      prog_en         <= 1'b0;
      armed           <= 1'b0;
      req             <= '0;
      start_seen      <= 1'b0;
      status_armed    <= 1'b0;
      status_show     <= 1'b0;
      rd_bit          <= 1'b0;
      dout_sr         <= 16'h0000;
      rd_left         <= 5'h00;
      serial_out_o    <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end else begin
      state           <= next_state;
      bit_cnt         <= next_cnt;
      sr              <= next_sr;
      addr            <= next_addr;
      prog_en         <= next_prog_en;
      armed           <= next_armed;
      req             <= next_req;
      start_seen      <= next_start_seen;
      status_armed    <= next_status_armed;
      status_show     <= next_status_show;
      rd_bit          <= next_rd_bit;
      dout_sr         <= next_dout;
      rd_left         <= next_left;
      serial_out_o    <= next_out;
      serial_out_oe_o <= next_oe;
    end
  end

  // Program group: timer first, then a byte-per-cycle sweep commits the data
  prog_req_t               act,        next_act;
  logic                    apply_on,   next_apply_on;
  logic [`BYTE_ADDR_W-1:0] apply_idx,  next_idx;
  logic [`BYTE_ADDR_W-1:0] apply_last, next_last;
  logic                    mem_we;
  logic [7:0]              mem_byte;
  logic [`TIMER_W-1:0]     tlen;
  logic                    timer_busy;
  logic                    timer_done;
  logic                    whole;

  assign prog_busy = timer_busy | timer_done | apply_on;

  always_comb begin
    next_act      = act;
    next_apply_on = apply_on;
    next_idx      = apply_idx;
    next_last     = apply_last;
    mem_we        = 1'b0;
    tlen          = `TIMER_W'(PROG_CYCLES);
    whole         = (go_req.kind == PK_ERASE_WHOLE_ARRAY) || (go_req.kind == PK_WRITE_WHOLE_ARRAY);
    if (go_req.kind == PK_ERASE_WHOLE_ARRAY) begin
      tlen = `TIMER_W'(ERASE_WHOLE_ARRAY_CYCLES);
    end else if (go_req.kind == PK_WRITE_WHOLE_ARRAY) begin
      tlen = `TIMER_W'(WRITE_WHOLE_ARRAY_CYCLES);
    end
    if (go) begin
      next_act = go_req;
      if (whole) begin
        next_idx  = `FIRST_BYTE;
        next_last = `LAST_BYTE;
      end else begin
        next_idx  = go_req.wide ? {go_req.addr[7:0], 1'b0} : go_req.addr;
        next_last = go_req.wide ? {go_req.addr[7:0], 1'b1} : go_req.addr;
      end
    end
    if (timer_done) begin
      next_apply_on = 1'b1;
    end
    if (apply_on) begin
      mem_we   = 1'b1;
      next_idx = apply_idx + `BYTE_ADDR_W'(1);
      if (apply_idx == apply_last) begin
        next_apply_on = 1'b0;
      end
    end
    // Write-all overwrites every byte, which already covers its built-in erase
    if ((act.kind == PK_ERASE) || (act.kind == PK_ERASE_WHOLE_ARRAY)) begin
      mem_byte = `ERASED_BYTE;
    end else if (act.wide) begin
      mem_byte = apply_idx[0] ? act.data[7:0] : act.data[15:8];
    end else begin
      mem_byte = act.data[7:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act        <= '0;
      apply_on   <= 1'b0;
      apply_idx  <= '0;
      apply_last <= '0;
    end else begin
      act        <= next_act;
      apply_on   <= next_apply_on;
      apply_idx  <= next_idx;
      apply_last <= next_last;
    end
  end

  // Array contents are nonvolatile, so reset leaves them alone
  always_ff @(posedge core_clk_i) begin
    if (mem_we) begin
      mem[apply_idx] <= mem_byte;
    end
  end

  program_timer u_timer (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .start_i    (go),
    .length_i   (tlen),
    .busy_o     (timer_busy),
    .done_o     (timer_done)
  );

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_read_launch;
    state == ST_SHIFT && pins.select && clk_rise && cnt_inc == addr_end && opc_dec == `OPC_READ;
  endsequence

  sequence s_cycle_start;
    go;
  endsequence

  property p_deselect_reset;
    !pins.select |=> state == ST_IDLE && bit_cnt == 5'h00;
  endproperty
  a_deselect_reset: assert property (p_deselect_reset) else $error("command not reset");

  property p_fall_tristate;
    sel_fall |=> !serial_out_oe_o;
  endproperty
  a_fall_tristate: assert property (p_fall_tristate) else $error("output not off");

  property p_busy_zero;
    serial_out_oe_o && $past(prog_busy) && prog_busy && state != ST_READ |-> !serial_out_o;
  endproperty
  a_busy_zero: assert property (p_busy_zero) else $error("busy not shown as zero");

  property p_ready_one;
    $fell(prog_busy) && status_show && pins.select && $past(pins.select) && state != ST_READ
      |=> serial_out_oe_o && serial_out_o;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready not shown");

  property p_cycle_runs;
    s_cycle_start |=> prog_busy [*8];
  endproperty
  a_cycle_runs: assert property (p_cycle_runs) else $error("cycle ended early");

  property p_disabled_no_cycle;
    fin && !prog_en |-> !go;
  endproperty
  a_disabled_no_cycle: assert property (p_disabled_no_cycle) else $error("program while off");

  property p_read_dummy;
    s_read_launch |=> serial_out_oe_o && !serial_out_o ##0 state == ST_READ;
  endproperty
  a_read_dummy: assert property (p_read_dummy) else $error("no dummy zero");

  property p_idle_ignore;
    state == ST_IDLE && pins.select && clk_rise && !pins.din |=> state == ST_IDLE;
  endproperty
  a_idle_ignore: assert property (p_idle_ignore) else $error("false start");

  property p_read_stable;
    state == ST_READ && pins.select && !clk_rise |=> $stable(serial_out_o);
  endproperty
  a_read_stable: assert property (p_read_stable) else $error("read bit moved");

  property p_keep_busy_deselected;
    prog_busy && !timer_done && !apply_on && !pins.select |=> prog_busy;
  endproperty
  a_keep_busy_deselected: assert property (p_keep_busy_deselected) else $error("cycle cut");

endmodule : eeprom_cmd
`default_nettype wire

// File: eeprom_cmd_cfg.svh
// Constants for the serial EEPROM command engine
`ifndef EEPROM_CMD_CFG_SVH
`define EEPROM_CMD_CFG_SVH

`define CORE_CLK_KHZ     25000
`define T_PROG_MS        6
`define T_ERASE_WHOLE_ARRAY_MS        6
`define T_WRITE_WHOLE_ARRAY_MS        15
`define T_SELECT_LOW_NS  250
`define TIMER_W          20

`define BYTE_ADDR_W      9
`define LAST_BYTE        9'h1FF
`define FIRST_BYTE       9'h000
`define SHIFT_W          25

`define OPC_BITS         5'h02
`define ADDR_BITS_X16    5'h08
`define ADDR_BITS_X8     5'h09
`define DATA_BITS_X16    5'h10
`define DATA_BITS_X8     5'h08

`define OPC_ERASE        2'h3
`define OPC_READ         2'h2
`define OPC_WRITE        2'h1
`define OPC_SPECIAL      2'h0
`define SUB_ERASE_WHOLE_ARRAY         2'h2
`define SUB_DISABLE      2'h0
`define SUB_ENABLE       2'h3
`define SUB_WRITE_WHOLE_ARRAY         2'h1

`define ERASED_BYTE      8'hFF
`define DUMMY_BIT        1'h0

`endif

// File: eeprom_cmd_pkg.sv
// Types shared by the serial EEPROM command engine
`include "eeprom_cmd_cfg.svh"

package eeprom_cmd_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_READ, ST_HOLD} link_state_t;

  typedef enum logic [2:0] {PK_NONE, PK_ERASE, PK_ERASE_WHOLE_ARRAY, PK_WRITE, PK_WRITE_WHOLE_ARRAY} prog_kind_t;

  typedef struct packed {
    logic select;
    logic sclk;
    logic din;
    logic wide;
  } pins_t;

  typedef struct packed {
    prog_kind_t                 kind;
    logic                       wide;
    logic [`BYTE_ADDR_W-1:0]    addr;
    logic [15:0]                data;
  } prog_req_t;

endpackage : eeprom_cmd_pkg

// File: program_timer.sv
// Self-timed program cycle counter
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_cmd_cfg.svh"

module program_timer (
  input  wire logic                core_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                start_i,
  input  wire logic [`TIMER_W-1:0] length_i,
  output logic                     busy_o,
  output logic                     done_o
);

  logic [`TIMER_W-1:0] count;
  logic [`TIMER_W-1:0] next_count;
  logic                next_done;

  always_comb begin
    next_count = count;
    next_done  = 1'b0;
    if (start_i) begin
      next_count = length_i;
    end else if (count != '0) begin
      next_count = count - `TIMER_W'(1);
      next_done  = (count == `TIMER_W'(1));
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count  <= '0;
      done_o <= 1'b0;
    end else begin
      count  <= next_count;
      done_o <= next_done;
    end
  end

  assign busy_o = (count != '0);

endmodule : program_timer
`default_nettype wire

// File: link_master.sv
// Bus master model driving the three-wire serial link
`timescale 1ns/1ps
`default_nettype none

module link_master (
  input  wire logic core_clk_i,
  input  wire logic serial_out_i,
  output var logic  select_o,
  output var logic  sclk_o,
  output var logic  serial_in_o
);
  initial begin
    select_o    = 1'b0;
    sclk_o      = 1'b0;
    serial_in_o = 1'b0;
  end

  // Half of the 320 ns link period
  task automatic half();
    repeat (4) @(negedge core_clk_i);
  endtask : half

  // Data is set up a half period before the rising edge
  task automatic pulse(input logic b);
    serial_in_o = b;
    half();
    sclk_o = 1'b1;
    half();
    sclk_o = 1'b0;
  endtask : pulse

  // Exactly n bits after the idle edges, which carry input low
  task automatic send(input logic [31:0] bits, input int n, input int lead);
    select_o = 1'b1;
    repeat (lead) pulse(1'b0);
    for (int i = n - 1; i >= 0; i--) pulse(bits[i]);
  endtask : send

  // Sampled just before the next rising edge, where the bit is settled
  task automatic recv(input int n, output logic [31:0] v);
    v = '0;
    for (int i = 0; i < n; i++) begin
      half();
      v = {v[30:0], serial_out_i};
      sclk_o = 1'b1;
      half();
      sclk_o = 1'b0;
    end
  endtask : recv

  // Clock stands low between frames; input does not keep its last value
  task automatic drop();
    select_o    = 1'b0;
    serial_in_o = ~serial_in_o;
    repeat (8) @(negedge core_clk_i);
  endtask : drop
endmodule : link_master

`default_nettype wire

// File: three_wire_serial_eeprom_commands_bench.sv
// Self-checking bench for the serial EEPROM command engine
`timescale 1ns/1ps
`default_nettype none

module three_wire_serial_eeprom_commands_bench;
  logic        clk;
  logic        rst_n;
  logic        wide;
  logic        out;
  logic        oe;
  logic        c_out;
  logic        c_oe;
  wire         sel;
  wire         sclk;
  wire         din;
  wire         dout = oe ? out : 1'bz;
  int          fails;
  int          samples_checked;
  logic [31:0] v;

  eeprom_cmd #(.CLK_TRIGGERED(1'b0), .PROG_CYCLES(40), .ERASE_WHOLE_ARRAY_CYCLES(40),
    .WRITE_WHOLE_ARRAY_CYCLES(60)) dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .select_i(sel),
    .sclk_i(sclk), .serial_in_i(din), .word_width_select_i(wide),
    .serial_out_o(out), .serial_out_oe_o(oe));

  // Clock-triggered variant listens to the same master; only its outputs are judged
  eeprom_cmd #(.CLK_TRIGGERED(1'b1), .PROG_CYCLES(40), .ERASE_WHOLE_ARRAY_CYCLES(40),
    .WRITE_WHOLE_ARRAY_CYCLES(60)) dut_clk_u (.core_clk_i(clk), .rst_n_i(rst_n), .select_i(sel),
    .sclk_i(sclk), .serial_in_i(din), .word_width_select_i(wide),
    .serial_out_o(c_out), .serial_out_oe_o(c_oe));

  link_master m_u (.core_clk_i(clk), .serial_out_i(dout), .select_o(sel),
    .sclk_o(sclk), .serial_in_o(din));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_of_test();
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Select high with no status pending: both outputs must stay off
  task automatic quiet(input string what);
    m_u.send(32'h0, 0, 0);
    repeat (6) @(negedge clk);
    chk(what, 16'h0, {14'h0, c_oe, oe});
    m_u.drop();
  endtask : quiet

  task automatic cmd(input logic [31:0] b, input int n);
    m_u.send(b, n, 2);
    m_u.drop();
  endtask : cmd

  // Busy shows 0, ready 1; a start bit then select low clears it
  task automatic poll(input logic busy_first);
    int k;
    m_u.send(32'h0, 0, 0);
    repeat (6) @(negedge clk);
    if (busy_first) chk("busy", 16'h0, {15'h0, dout});
    for (k = 0; k < 2000 && dout !== 1'b1; k++) @(negedge clk);
    if (k == 2000) begin
      fails++;
      end_of_test();
    end
    chk("ready", 16'h7, {13'h0, c_oe, c_out, dout});
    m_u.send(32'h1, 1, 0);
    m_u.drop();
    quiet("oe cleared");
  endtask : poll

  task automatic rd8(input logic [8:0] a, input logic [7:0] d, input logic [7:0] d2);
    m_u.send({3'b110, a}, 12, 0);
    m_u.recv(9, v);
    chk("read", {8'h0, d}, v[15:0]);
    m_u.recv(8, v);
    chk("next read", {8'h0, d2}, v[15:0]);
    m_u.drop();
  endtask : rd8

  task automatic t_protect();
    cmd({3'b101, 9'h005, 8'hA5}, 20);
    quiet("no cycle when off");
    cmd({3'b100, 9'h180}, 12);
    cmd({3'b100, 9'h100}, 12);
    poll(1'b1);
    rd8(9'h005, 8'hFF, 8'hFF);
  endtask : t_protect

  task automatic t_write();
    m_u.send({3'b101, 9'h005, 8'h3C}, 20, 2);
    repeat (60) @(negedge clk);
    m_u.drop();
    m_u.send(32'h0, 0, 0);
    repeat (6) @(negedge clk);
    chk("start on last edge", 16'h3, {14'h0, c_oe, c_out});
    chk("start on select fall", 16'h2, {14'h0, oe, out});
    poll(1'b1);
    m_u.send({3'b101, 5'h00}, 8, 0);
    m_u.drop();
    rd8(9'h005, 8'h3C, 8'hFF);
  endtask : t_write

  task automatic t_erase();
    cmd({3'b111, 9'h005}, 12);
    repeat (100) begin
      @(negedge clk);
      if ({oe, c_oe} !== 2'b00) chk("oe low", 16'h0, {14'h0, oe, c_oe});
    end
    poll(1'b0);
    rd8(9'h004, 8'hFF, 8'hFF);
  endtask : t_erase

  task automatic t_write_whole_array();
    cmd({3'b100, 9'h000}, 12);
    cmd({3'b100, 9'h080, 8'h12}, 20);
    rd8(9'h000, 8'hFF, 8'hFF);
    cmd({3'b100, 9'h180}, 12);
    cmd({3'b100, 9'h080, 8'h5A}, 20);
    poll(1'b1);
    rd8(9'h1FF, 8'h5A, 8'h5A);
  endtask : t_write_whole_array

  task automatic t_wide();
    wide = 1'b1;
    repeat (8) @(negedge clk);
    m_u.send({3'b110, 8'h00}, 11, 0);
    m_u.recv(17, v);
    m_u.drop();
    chk("wide read", 16'h5A5A, v[15:0]);
    chk("dummy", 16'h0, {15'h0, v[16]});
  endtask : t_wide

  initial begin
    rst_n           = 1'b0;
    wide            = 1'b0;
    fails           = 0;
    samples_checked = 0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("oe idle", 16'h0, {15'h0, oe});
    t_protect();
    t_write();
    t_erase();
    t_write_whole_array();
    t_wide();
    end_of_test();
  end
endmodule : three_wire_serial_eeprom_commands_bench

`default_nettype wire
